// [src/dim_init_mode.sv]
// DRAM device init sequencing, mode registers and burst ordering
//
// Overview of operation
// - Termination off until reset released and enable seen
// - Bit three selects sequential or interleaved read order
// - Bits zero, one select chop, full or on-the-fly
// - Full read wraps in group; interleave XORs beat
// - Chopped read drives four then goes high impedance
// - Chopped write uses column bit two only
// - Lock loop reset bit clears itself
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`include "dim_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module dim_init_mode (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output      logic              hreadyout,
  output      logic              hresp,
  output      logic [31:0]       hrdata,
  input  wire dim_pkg::dim_pins_t dram_pins,
  output      logic              term_active,
  output      logic              init_ready,
  output      logic              beat_valid,
  output      logic              beat_write,
  output      logic [2:0]        beat_col,
  output      logic              dq_oe_n
);

  dim_pkg::dim_regs_t cur_ff;
  dim_pkg::dim_regs_t nxt_ff;
  dim_pkg::dim_pins_t p;
  logic               ck_rise;
  logic               ck_edge;
  logic               cmd_ok;
  logic               is_mrs;
  logic               is_cal;
  logic               is_rd;
  logic               is_wr;
  logic               live;
  logic [2:0]         exp_bank;
  logic [31:0]        status;

  // ****************************************
  // Pin decode
  // ****************************************
  // Only the second synchroniser stage is read
  assign p       = cur_ff.s2;
  assign ck_rise = p.ck & ~cur_ff.ck_q;
  assign ck_edge = p.ck ^ cur_ff.ck_q;
  assign cmd_ok  = ck_rise & p.clk_en_pin & ~p.cs_n & p.dram_reset_low;
  assign is_mrs  = cmd_ok & ~p.ras_n & ~p.cas_n & ~p.we_n;
  assign is_cal  = cmd_ok & p.ras_n & p.cas_n & ~p.we_n & p.addr[`DIM_ADDR_CAL];
  assign is_rd   = cmd_ok & p.ras_n & ~p.cas_n & p.we_n;
  assign is_wr   = cmd_ok & p.ras_n & ~p.cas_n & ~p.we_n;
  assign live    = (cur_ff.st == dim_pkg::DIM_INIT) | (cur_ff.st == dim_pkg::DIM_CAL)
                 | (cur_ff.st == dim_pkg::DIM_READY);
  assign status  = {21'h0, cur_ff.bu.busy, cur_ff.cal_cnt != 16'h0,
                    cur_ff.lock_cnt != 16'h0, cur_ff.term_active, cur_ff.ready,
                    cur_ff.order_err, cur_ff.step, cur_ff.st};

  always_comb begin
    unique case (cur_ff.step)
      2'h0: exp_bank = `DIM_BANK_MR2;
      2'h1: exp_bank = `DIM_BANK_MR3;
      2'h2: exp_bank = `DIM_BANK_MR1;
      2'h3: exp_bank = `DIM_BANK_MR0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_ff            = cur_ff;
    nxt_ff.s1         = dram_pins;
    nxt_ff.s2         = cur_ff.s1;
    nxt_ff.ck_q       = cur_ff.s2.ck;
    nxt_ff.beat_valid = 1'b0;
    nxt_ff.dq_oe_n    = 1'b1;

    if (ck_rise && cur_ff.lock_cnt != 16'h0) begin
      nxt_ff.lock_cnt = cur_ff.lock_cnt - 16'h1;
    end
    if (ck_rise && cur_ff.cal_cnt != 16'h0) begin
      nxt_ff.cal_cnt = cur_ff.cal_cnt - 16'h1;
    end
    if (ck_rise && cur_ff.dll_pend) begin
      nxt_ff.dll_pend                  = 1'b0;
      nxt_ff.mr[0][`DIM_MR0_DLL_RST]   = 1'b0;
    end

    // Burst beats, two per link clock
    if (ck_edge && cur_ff.bu.busy) begin
      nxt_ff.beat_valid = 1'b1;
      nxt_ff.beat_write = cur_ff.bu.write;
      // wrap in group, or XOR order
      if (cur_ff.bu.ilv) begin
        nxt_ff.beat_col = cur_ff.bu.col ^ cur_ff.bu.beat;
      end else begin
        nxt_ff.beat_col = {cur_ff.bu.col[2] ^ cur_ff.bu.beat[2],
                           cur_ff.bu.col[1:0] + cur_ff.bu.beat[1:0]};
      end
      nxt_ff.dq_oe_n = cur_ff.bu.write | (cur_ff.bu.chop & cur_ff.bu.beat[2]);
      nxt_ff.bu.beat = cur_ff.bu.beat + 3'h1;
      nxt_ff.bu.busy = (cur_ff.bu.beat != 3'h7);
    end

    if (live && (is_rd || is_wr) && cur_ff.st == dim_pkg::DIM_READY) begin
      nxt_ff.bu.busy  = 1'b1;
      nxt_ff.bu.write = is_wr;
      nxt_ff.bu.beat  = 3'h0;
      nxt_ff.bu.ilv   = cur_ff.mr[0][`DIM_MR0_TYPE] & is_rd;
      // fixed chop, fixed full or on the fly
      unique case (cur_ff.mr[0][1:0])
        `DIM_BL_CHOP4: nxt_ff.bu.chop = 1'b1;
        `DIM_BL_OTF:   nxt_ff.bu.chop = ~p.addr[`DIM_ADDR_CHOP_N];
        `DIM_BL_FULL8: nxt_ff.bu.chop = 1'b0;
        default:       nxt_ff.bu.chop = 1'b0;
      endcase
      // writes ascend from column bit two
      nxt_ff.bu.col = is_wr ? {p.addr[2], 2'h0} : p.addr[2:0];
    end

    if (live && is_mrs) begin
      nxt_ff.mr[p.bank_select_bits[1:0]] = p.addr;
      if (p.bank_select_bits[1:0] == 2'h0 && p.addr[`DIM_MR0_DLL_RST]) begin
        nxt_ff.dll_pend = 1'b1;
        nxt_ff.lock_cnt = cur_ff.lock_cfg;
      end
    end

    unique case (cur_ff.st)
      dim_pkg::DIM_RESET: begin
        if (p.dram_reset_low) begin
          nxt_ff.st = dim_pkg::DIM_WAIT_CKE;
        end
      end
      dim_pkg::DIM_WAIT_CKE: begin
        if (ck_rise && p.clk_en_pin) begin
          nxt_ff.st = dim_pkg::DIM_INIT;
        end
      end
      dim_pkg::DIM_INIT: begin
        if (is_mrs) begin
          // Out of order programming is flagged, not refused
          if (p.bank_select_bits != exp_bank) begin
            nxt_ff.order_err = 1'b1;
          end
          nxt_ff.step = cur_ff.step + 2'h1;
        end
        if (is_cal) begin
          nxt_ff.cal_cnt = cur_ff.cal_cfg;
          nxt_ff.st      = dim_pkg::DIM_CAL;
        end
      end
      dim_pkg::DIM_CAL: begin
        if (cur_ff.lock_cnt == 16'h0 && cur_ff.cal_cnt == 16'h0) begin
          nxt_ff.st    = dim_pkg::DIM_READY;
          nxt_ff.ready = 1'b1;
        end
      end
      dim_pkg::DIM_READY: begin
        nxt_ff.ready = 1'b1;
      end
    endcase

    nxt_ff.term_active = p.termination_ctrl & p.dram_reset_low & live;

    // ****************************************
    // AHB-Lite slave, zero wait states
    // ****************************************
    nxt_ff.wr_pend = 1'b0;
    if (cur_ff.wr_pend) begin
      unique case (cur_ff.wr_addr)
        // A new order error in the clearing cycle wins over the clear
        `DIM_OFS_STATUS:  nxt_ff.order_err = (is_mrs && cur_ff.st == dim_pkg::DIM_INIT
                                             && p.bank_select_bits != exp_bank)
                                           | (cur_ff.order_err & ~hwdata[`DIM_ST_ORDER_ERR]);
        `DIM_OFS_LOCKCFG: nxt_ff.lock_cfg = hwdata[15:0];
        `DIM_OFS_CALCFG:  nxt_ff.cal_cfg  = hwdata[15:0];
        default:          nxt_ff.wr_addr  = cur_ff.wr_addr;
      endcase
    end
    if (hsel && htrans[1] && hready) begin
      nxt_ff.wr_pend = hwrite;
      nxt_ff.wr_addr = haddr[7:0];
      if (!hwrite) begin
        unique case (haddr[7:0])
          `DIM_OFS_STATUS:  nxt_ff.hrdata = status;
          `DIM_OFS_MODE0:   nxt_ff.hrdata = {19'h0, cur_ff.mr[0]};
          `DIM_OFS_MODE1:   nxt_ff.hrdata = {19'h0, cur_ff.mr[1]};
          `DIM_OFS_MODE2:   nxt_ff.hrdata = {19'h0, cur_ff.mr[2]};
          `DIM_OFS_MODE3:   nxt_ff.hrdata = {19'h0, cur_ff.mr[3]};
          `DIM_OFS_LOCKCFG: nxt_ff.hrdata = {16'h0, cur_ff.lock_cfg};
          `DIM_OFS_CALCFG:  nxt_ff.hrdata = {16'h0, cur_ff.cal_cfg};
          default:          nxt_ff.hrdata = 32'h0;
        endcase
      end
    end

    // Pin reset wipes the mode contents; they read as zero afterwards
    if (!p.dram_reset_low) begin
      nxt_ff.st          = dim_pkg::DIM_RESET;
      nxt_ff.step        = 2'h0;
      nxt_ff.mr          = '0;
      nxt_ff.dll_pend    = 1'b0;
      nxt_ff.lock_cnt    = 16'h0;
      nxt_ff.cal_cnt     = 16'h0;
      nxt_ff.bu.busy     = 1'b0;
      nxt_ff.ready       = 1'b0;
      nxt_ff.term_active = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_ff          <= '0;
      cur_ff.hready_o <= 1'b1;
      cur_ff.dq_oe_n  <= 1'b1;
      cur_ff.lock_cfg <= `DIM_LOCK_CYC;
      cur_ff.cal_cfg  <= `DIM_CAL_CYC;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign hreadyout   = cur_ff.hready_o;
  assign hresp       = cur_ff.hresp_o;
  assign hrdata      = cur_ff.hrdata;
  assign term_active = cur_ff.term_active;
  assign init_ready  = cur_ff.ready;
  assign beat_valid  = cur_ff.beat_valid;
  assign beat_write  = cur_ff.beat_write;
  assign beat_col    = cur_ff.beat_col;
  assign dq_oe_n     = cur_ff.dq_oe_n;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking dim_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_term_in_reset: assert property (!p.dram_reset_low |=> !term_active)
    else $error("termination active during pin reset");
  a_term_before_cke: assert property ((cur_ff.st == dim_pkg::DIM_WAIT_CKE) && !ck_rise
    |=> !term_active)
    else $error("termination active before enable registered");
  a_type_select: assert property (is_rd && cur_ff.st == dim_pkg::DIM_READY
    |=> cur_ff.bu.ilv == $past(cur_ff.mr[0][3]))
    else $error("burst type not taken from mode bit");
  a_len_chop: assert property (is_rd && cur_ff.st == dim_pkg::DIM_READY
    && cur_ff.mr[0][1:0] == 2'h2 |=> cur_ff.bu.chop)
    else $error("fixed chop not applied");
  a_seq_group: assert property (ck_edge && cur_ff.bu.busy && !cur_ff.bu.ilv
    && !cur_ff.bu.write && cur_ff.bu.beat == 3'h4
    |=> beat_col[2] != $past(cur_ff.bu.col[2]))
    else $error("full read did not move to other group");
  a_chop_tristate: assert property (ck_edge && cur_ff.bu.busy && cur_ff.bu.chop
    && cur_ff.bu.beat[2] |=> beat_valid && dq_oe_n)
    else $error("chopped read drove last beats");
  a_write_order: assert property (ck_edge && cur_ff.bu.busy && cur_ff.bu.write
    |=> beat_col[1:0] == $past(cur_ff.bu.beat[1:0]) && dq_oe_n)
    else $error("chopped write order wrong");
  a_dll_selfclr: assert property ($rose(cur_ff.mr[0][8]) |-> ##[1:40] !cur_ff.mr[0][8])
    else $error("lock loop reset bit did not clear");

  c_reach_ready: cover property ($rose(cur_ff.ready));
  c_chop_read:   cover property (beat_valid && dq_oe_n && !beat_write);
  c_ilv_burst:   cover property (cur_ff.bu.busy && cur_ff.bu.ilv);

endmodule : dim_init_mode

`default_nettype wire

// [src/dim_defs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef DIM_DEFS_SVH
`define DIM_DEFS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define DIM_OFS_STATUS   8'h00
`define DIM_OFS_MODE0    8'h04
`define DIM_OFS_MODE1    8'h08
`define DIM_OFS_MODE2    8'h0C
`define DIM_OFS_MODE3    8'h10
`define DIM_OFS_LOCKCFG  8'h14
`define DIM_OFS_CALCFG   8'h18

// ****************************************
// Status fields
// ****************************************
`define DIM_ST_ORDER_ERR 5
`define DIM_ST_READY     6

// ****************************************
// Mode register fields and command address bits
// ****************************************
`define DIM_MR0_DLL_RST  8
`define DIM_MR0_TYPE     3
`define DIM_BL_FULL8     2'h0
`define DIM_BL_OTF       2'h1
`define DIM_BL_CHOP4     2'h2
`define DIM_ADDR_CHOP_N  12
`define DIM_ADDR_CAL     10

// ****************************************
// Bank codes in programming order
// ****************************************
`define DIM_BANK_MR2     3'h2
`define DIM_BANK_MR3     3'h3
`define DIM_BANK_MR1     3'h1
`define DIM_BANK_MR0     3'h0

// ****************************************
// Timing counts in link clock cycles
// ****************************************
`define DIM_LOCK_CYC     16'h0200
`define DIM_CAL_CYC      16'h0200

`endif

// [src/dim_pkg.sv]
// Types shared by the DRAM init and mode block
package dim_pkg;

  typedef enum logic [2:0] {
    DIM_RESET    = 3'h0,
    DIM_WAIT_CKE = 3'h1,
    DIM_INIT     = 3'h3,
    DIM_CAL      = 3'h2,
    DIM_READY    = 3'h6
  } dim_state_t;

  typedef struct packed {
    logic        dram_reset_low;
    logic        clk_en_pin;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  bank_select_bits;
    logic [12:0] addr;
    logic        termination_ctrl;
    logic        ck;
  } dim_pins_t;

  typedef struct packed {
    logic       busy;
    logic       write;
    logic       ilv;
    logic       chop;
    logic [2:0] col;
    logic [2:0] beat;
  } dim_burst_t;

  typedef struct packed {
    dim_pins_t        s1;
    dim_pins_t        s2;
    logic             ck_q;
    dim_state_t       st;
    logic [1:0]       step;
    logic             order_err;
    logic [3:0][12:0] mr;
    logic             dll_pend;
    logic [15:0]      lock_cnt;
    logic [15:0]      cal_cnt;
    logic [15:0]      lock_cfg;
    logic [15:0]      cal_cfg;
    dim_burst_t       bu;
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic [31:0]      hrdata;
    logic             hready_o;
    logic             hresp_o;
    logic             term_active;
    logic             ready;
    logic             beat_valid;
    logic             beat_write;
    logic             dq_oe_n;
    logic [2:0]       beat_col;
  } dim_regs_t;

endpackage : dim_pkg

// [tb/dim_ctrl_model.sv]
// Behavioural memory controller driving the device pins
`timescale 1ns/1ns
`default_nettype none

module dim_ctrl_model #(
  parameter int RST_WAIT_NS = 500000,
  parameter int GAP_CK      = 8
) (
  output var dim_pkg::dim_pins_t pins
);
  logic ck_run;

  // ****************************************
  // Link clock, still during pin reset
  // ****************************************
  // termination control static, held high
  initial begin
    ck_run = 1'h0;
    pins = '0;
    pins.termination_ctrl = 1'h1;
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = 4'hF;
  end

  always begin
    #80;
    if (ck_run) begin
      pins.ck = ~pins.ck;
    end
  end

  // ****************************************
  // Command tasks
  // ****************************************
  // Unused lines toggle so a stale value never passes
  task automatic idle();
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = 4'h7;
    pins.bank_select_bits = ~pins.bank_select_bits;
    pins.addr = ~pins.addr;
  endtask : idle

  // enable low first, reset held past 100 ns
  task automatic hold_reset();
    ck_run = 1'h0;
    pins.clk_en_pin = 1'h0;
    #20;
    pins.dram_reset_low = 1'h0;
    #200;
  endtask : hold_reset

  // wait, clock, idle, enable, exit time
  task automatic release_reset();
    pins.dram_reset_low = 1'h1;
    #(RST_WAIT_NS);
    ck_run = 1'h1;
    idle();
    repeat (6) @(negedge pins.ck);
    pins.clk_en_pin = 1'h1;
    repeat (6) @(negedge pins.ck);
  endtask : release_reset

  task automatic cmd(input logic [3:0] ctl, input logic [2:0] bank, input logic [12:0] a);
    @(negedge pins.ck);
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = ctl;
    pins.bank_select_bits = bank;
    pins.addr = a;
    @(negedge pins.ck);
    idle();
    repeat (GAP_CK) @(negedge pins.ck);
  endtask : cmd
endmodule : dim_ctrl_model
`default_nettype wire

// [tb/dim_init_mode_bench.sv]
// Self-checking bench for the DRAM init and mode block
`include "dim_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module dim_init_mode_bench;
  logic               hclk;
  logic               hresetn;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [31:0]        hwdata;
  wire logic          hready;
  wire logic          hresp;
  wire logic [31:0]   hrdata;
  wire logic          term_active;
  wire logic          init_ready;
  wire logic          beat_valid;
  wire logic          beat_write;
  wire logic [2:0]    beat_col;
  wire logic          dq_oe_n;
  dim_pkg::dim_pins_t pins;
  int                 num_errors;
  int                 samples_checked;
  logic [4:0]         beats[$];
  logic [31:0]        rd;
  // Case: write, a12, interleave, length code, column
  logic [7:0]         cases[9] = '{8'h15, 8'h35, 8'h06, 8'h23, 8'h0A, 8'h6F, 8'hB7, 8'h85,
                                   8'h19};

  dim_ctrl_model #(.RST_WAIT_NS(500000), .GAP_CK(8)) ctrl (.pins(pins));

  dim_init_mode dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .dram_pins(pins),
    .term_active(term_active), .init_ready(init_ready), .beat_valid(beat_valid),
    .beat_write(beat_write), .beat_col(beat_col), .dq_oe_n(dq_oe_n));

  initial hclk = 1'h0;
  always #10 hclk = ~hclk;

  always @(posedge hclk) begin
    if (beat_valid === 1'h1) begin
      beats.push_back({beat_write, dq_oe_n, beat_col});
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask : ahb

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'h0, a, 32'h0);
    chk(name, rd, exp);
  endtask : rdchk

  task automatic burst(input logic [7:0] c);
    logic       chop;
    logic [2:0] b;
    logic [2:0] exp;
    ctrl.cmd(4'h0, `DIM_BANK_MR0, {9'h000, c[5], 1'h0, c[4:3]});
    beats.delete();
    ctrl.cmd({3'h2, ~c[7]}, 3'h0, {c[6], 9'h000, c[2:0]});
    chop = (c[4:3] == 2'h2) || (c[4:3] == 2'h1 && !c[6]);
    chk("beat count", 32'(beats.size()), 32'h8);
    for (int i = 0; i < beats.size(); i++) begin
      b = 3'(i);
      exp = c[7] ? ({c[2], 2'h0} + b) : c[5] ? (c[2:0] ^ b) : {c[2] ^ b[2], c[1:0] + b[1:0]};
      chk("beat_write", 32'(beats[i][4]), 32'(c[7]));
      chk("dq_oe_n", 32'(beats[i][3]), 32'(c[7] || (chop && i > 3)));
      if (!(chop && i > 3)) begin
        chk("beat_col", 32'(beats[i][2:0]), 32'(exp));
      end
    end
    $display("Test burst %h done", c);
  endtask : burst

  task automatic test_done();
    $display("Checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    hresetn = 1'h0;
    num_errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk("hresp", 32'(hresp), 32'h0);
    chk("term_active", 32'(term_active), 32'h0);
    rdchk("lock_cfg", `DIM_OFS_LOCKCFG, 32'h0000_0200);
    rdchk("cal_cfg", `DIM_OFS_CALCFG, 32'h0000_0200);
    ahb(1'h1, `DIM_OFS_LOCKCFG, 32'h4);
    ahb(1'h1, `DIM_OFS_CALCFG, 32'h4);
    ahb(1'h1, 8'h1C, 32'hFFFF_FFFF);
    rdchk("lock_cfg", `DIM_OFS_LOCKCFG, 32'h4);
    rdchk("unmapped", 8'h1C, 32'h0);
    $display("Test reset values done");
    ctrl.release_reset();
    chk("term_active", 32'(term_active), 32'h1);
    ctrl.cmd(4'h5, 3'h0, 13'h0005);
    chk("early beats", 32'(beats.size()), 32'h0);
    ctrl.cmd(4'h0, `DIM_BANK_MR3, 13'h0000);
    rdchk("order_err", `DIM_OFS_STATUS, 32'h0000_00AB);
    ahb(1'h1, `DIM_OFS_STATUS, 32'h20);
    $display("Test order error done");
    ctrl.hold_reset();
    chk("term_active", 32'(term_active), 32'h0);
    rdchk("status", `DIM_OFS_STATUS, 32'h0);
    ctrl.release_reset();
    ctrl.cmd(4'h0, `DIM_BANK_MR2, 13'h0000);
    ctrl.cmd(4'h0, `DIM_BANK_MR3, 13'h0000);
    ctrl.cmd(4'h0, `DIM_BANK_MR1, 13'h0000);
    ctrl.cmd(4'h0, `DIM_BANK_MR0, 13'h0102);
    chk("init_ready", 32'(init_ready), 32'h0);
    ctrl.cmd(4'h6, 3'h0, 13'h0400);
    for (int i = 0; i < 400 && init_ready !== 1'h1; i++) begin
      @(posedge hclk);
    end
    chk("init_ready", 32'(init_ready), 32'h1);
    ahb(1'h0, `DIM_OFS_STATUS, 32'h0);
    chk("state", 32'(rd[`DIM_ST_ORDER_ERR:0]), 32'h6);
    rdchk("mode0", `DIM_OFS_MODE0, 32'h2);
    $display("Test init sequence done");
    foreach (cases[k]) begin
      burst(cases[k]);
    end
    test_done();
  end

  // Long enough for both power-ups and every burst case
  initial begin
    #1500000;
    num_errors++;
    $display("Error watchdog expected end seen hang");
    test_done();
  end
endmodule : dim_init_mode_bench
`default_nettype wire
